// >>> core/pxa_pkg.sv
// pxa_pkg: register map, field layout and encodings of the pixel
// accelerator flag/source register slice.
// assumes: an APB slave decoding an 8-bit byte offset, 32-bit data.
package pxa_pkg;

  // address decode width and register byte offsets
  localparam int PXA_AW = 8;
  localparam logic [PXA_AW-1:0] OFF_FLAG = 8'h04;
  localparam logic [PXA_AW-1:0] OFF_CLR = 8'h08;
  localparam logic [PXA_AW-1:0] OFF_FG_BASE = 8'h0c;
  localparam logic [PXA_AW-1:0] OFF_FG_GAP = 8'h10;
  localparam logic [PXA_AW-1:0] OFF_BG_BASE = 8'h14;
  localparam logic [PXA_AW-1:0] OFF_BG_GAP = 8'h18;
  localparam logic [PXA_AW-1:0] OFF_FG_PCTL = 8'h1c;

  // every register of the slice resets to zero
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // flag / clear bit positions
  localparam int NFLAGS = 6;
  localparam int BIT_BAD_CFG = 5;
  localparam int BIT_LUT_DONE = 4;
  localparam int BIT_LUT_CONF = 3;
  localparam int BIT_LINE_MARK = 2;
  localparam int BIT_XFER_DONE = 1;
  localparam int BIT_BUS_ERR = 0;

  // foreground pixel control field positions
  localparam int PCTL_ALPHA_LSB = 24;
  localparam int PCTL_MODE_LSB = 16;
  localparam int PCTL_CNT_LSB = 8;
  localparam int PCTL_LLEN_BIT = 5;
  localparam int PCTL_LPF_BIT = 4;
  localparam int PCTL_FMT_LSB = 0;

  // writable bit masks; reserved bits are never stored
  localparam logic [31:0] GAP_MASK = 32'h0000_3fff;
  localparam logic [31:0] PCTL_XFER_LOCKED = 32'hff03_000f;
  localparam logic [31:0] PCTL_LUT_LOCKED = 32'h0000_ff10;

  // pixel formats
  localparam logic [3:0] FMT_ARGB8888 = 4'h0;
  localparam logic [3:0] FMT_RGB888 = 4'h1;
  localparam logic [3:0] FMT_RGB565 = 4'h2;
  localparam logic [3:0] FMT_ARGB1555 = 4'h3;
  localparam logic [3:0] FMT_ARGB4444 = 4'h4;
  localparam logic [3:0] FMT_L8 = 4'h5;
  localparam logic [3:0] FMT_AL44 = 4'h6;
  localparam logic [3:0] FMT_AL88 = 4'h7;
  localparam logic [3:0] FMT_L4 = 4'h8;
  localparam logic [3:0] FMT_A8 = 4'h9;
  localparam logic [3:0] FMT_A4 = 4'ha;

  // foreground alpha modes
  localparam logic [1:0] AM_KEEP = 2'h0;
  localparam logic [1:0] AM_PREDEF = 2'h1;
  localparam logic [1:0] AM_SCALE = 2'h2;

  // pixel conversion modes of the transfer
  localparam logic [1:0] PC_COPY = 2'h0;
  localparam logic [1:0] PC_CONV = 2'h1;
  localparam logic [1:0] PC_BLEND = 2'h2;
  localparam logic [1:0] PC_FILL = 2'h3;

  // rounding term of the divide by 255
  localparam logic [15:0] DIV_ROUND = 16'h0080;

endpackage : pxa_pkg

// >>> core/pxa_wreg.sv
// pxa_wreg: one 32-bit software register with byte strobes.
// assumes: wr is a one-cycle APB write pulse; wmask picks the bits that
// this write may change (reserved and locked bits stay put).
`timescale 1ns/1ps
module pxa_wreg
  import pxa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [3:0] strb,
  input wire logic [31:0] wdata,
  input wire logic [31:0] wmask,
  output logic [31:0] q
);

  logic [31:0] merged; // write data over kept bits
  logic [31:0] reg_d; // next value, per byte lane

  assign merged = (wdata & wmask) | (q & ~wmask);

  // byte lanes: an unstrobed lane keeps its old value
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign reg_d[8*i +: 8] = (wr && strb[i]) ? merged[8*i +: 8] : q[8*i +: 8];
  end

  // storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= REG_RESET;
    end else begin
      q <= reg_d;
    end
  end

endmodule : pxa_wreg

// >>> core/pxa_alpha.sv
// pxa_alpha: foreground alpha selection per the alpha mode.
// assumes: fetched alpha arrives from the datapath, one pixel a cycle.
`timescale 1ns/1ps
module pxa_alpha
  import pxa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic [7:0] predef,
  input wire logic [7:0] fetched,
  output logic [7:0] alpha_q
);

  logic [15:0] prod; // predefined times fetched
  logic [15:0] prod_r; // rounded product
  logic [15:0] scaled; // exact rounded divide by 255
  logic [7:0] alpha_d;

  assign prod = {8'h00, predef} * {8'h00, fetched};
  assign prod_r = prod + DIV_ROUND;
  // x/255 without a divider: (p + (p >> 8)) >> 8
  assign scaled = (prod_r + (prod_r >> 8)) >> 8;

  // mode select; reserved code falls back to fetched alpha
  assign alpha_d = (mode == AM_PREDEF) ? predef :
                   (mode == AM_SCALE) ? scaled[7:0] : fetched;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alpha_q <= 8'h00;
    end else begin
      alpha_q <= alpha_d;
    end
  end

endmodule : pxa_alpha

// >>> core/pxa_regs.sv
// pxa_regs: flag, clear, source address/gap and foreground pixel
// control registers of the pixel accelerator, on an APB4 slave.
// assumes: control register, datapath and lut engine sit outside and
// trade levels and one-cycle event pulses with this slice.
//
// Overview of operation
// - flag bad configuration at bit 5
// - flag lut load done at bit 4
// - flag forbidden lut access at bit 3
// - flag line mark reached at bit 2
// - flag transfer complete at bit 1
// - flag bus access error at bit 0
// - write one clears flag, clear self-clears
// - byte, half-word and word writes accepted
// - foreground base alignment checked at enable
// - background base alignment checked at enable
// - odd foreground gap bad for 4-bit formats
// - odd background gap bad for 4-bit formats
// - source fields locked while transfer enabled
// - alpha mode keeps, replaces or scales alpha
// - lut count is field plus one, locked
// - software sets lut load, hardware clears
// - lut load ends on stop, done, error
// - lut load refused during transfer/other load
// - four-bit pixel format code decoded
// - transfer start raises config error abort
// - interrupt when flag and enable both set
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module pxa_regs
  import pxa_pkg::*;
(
  // apb4 slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PXA_AW-1:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // levels from the control register and rest of the unit
  input wire logic transfer_enable_bit,
  input wire logic transfer_stop_bit,
  input wire logic bg_lut_load_enable,
  input wire logic [1:0] pixel_conv_mode,
  input wire logic [3:0] bg_pixel_format,
  input wire logic [NFLAGS-1:0] irq_enable,
  input wire logic ext_bad_config,
  // event pulses from the datapath
  input wire logic fg_lut_done,
  input wire logic bg_lut_done,
  input wire logic line_mark_hit,
  input wire logic transfer_done,
  input wire logic bus_access_error,
  input wire logic fg_lut_sw_access,
  input wire logic bg_lut_sw_access,
  input wire logic [7:0] fg_fetched_alpha,
  // towards the datapath
  output logic [NFLAGS-1:0] flag_status,
  output logic irq,
  output logic config_error,
  output logic lut_conflict,
  output logic [31:0] fg_base_address,
  output logic [13:0] fg_line_gap_pixels,
  output logic [31:0] bg_base_address,
  output logic [13:0] bg_line_gap_pixels,
  output logic [7:0] fg_predefined_alpha,
  output logic [1:0] fg_alpha_mode,
  output logic [8:0] fg_lut_entry_count,
  output logic fg_lut_load_enable,
  output logic fg_lut_pixel_format,
  output logic [3:0] fg_pixel_format,
  output logic [7:0] fg_alpha
);

  // ---------------------------------------------------------------
  // format checks
  // ---------------------------------------------------------------

  // true when a format/base/gap triple breaks a layout constraint
  function automatic logic layout_bad(input logic [3:0] fmt,
                                      input logic [31:0] addr,
                                      input logic [13:0] gap);
    logic w32;
    logic w16;
    logic nib;
    w32 = (fmt == FMT_ARGB8888);
    w16 = (fmt == FMT_RGB565) || (fmt == FMT_ARGB1555) ||
          (fmt == FMT_ARGB4444) || (fmt == FMT_AL88);
    nib = (fmt == FMT_L4) || (fmt == FMT_A4);
    // a reserved format code can never be fetched either
    return (w32 && (addr[1:0] != 2'b00)) || (w16 && addr[0]) ||
           (nib && gap[0]) || (fmt > FMT_A4);
  endfunction : layout_bad

  // formats that index a lut
  function automatic logic indirect(input logic [3:0] fmt);
    return (fmt == FMT_L8) || (fmt == FMT_AL44) ||
           (fmt == FMT_AL88) || (fmt == FMT_L4);
  endfunction : indirect

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------

  wire setup_rd = psel && !penable && !pwrite; // read data captured here
  wire access = psel && penable; // zero wait state access
  wire hit_flag = (paddr == OFF_FLAG);
  wire hit_clr = (paddr == OFF_CLR);
  wire hit_fgb = (paddr == OFF_FG_BASE);
  wire hit_fgg = (paddr == OFF_FG_GAP);
  wire hit_bgb = (paddr == OFF_BG_BASE);
  wire hit_bgg = (paddr == OFF_BG_GAP);
  wire hit_pctl = (paddr == OFF_FG_PCTL);
  wire hit_any = hit_flag || hit_clr || hit_fgb || hit_fgg ||
                 hit_bgb || hit_bgg || hit_pctl;
  wire wr_acc = access && pwrite && hit_any;
  wire wr_clr = wr_acc && hit_clr;
  wire wr_pctl = wr_acc && hit_pctl;

  // always ready; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------

  logic [NFLAGS-1:0] flag_q; // sticky event flags
  logic [NFLAGS-1:0] flag_d;
  logic [NFLAGS-1:0] clr_q; // pending clear strobes
  logic [NFLAGS-1:0] clr_d;
  logic llen_q; // foreground lut load enable
  logic llen_d;
  logic llen_was_q; // last cycle's load enable, for start edge
  logic ten_was_q; // last cycle's transfer enable, for start edge
  logic cfg_err_q; // registered abort pulse
  logic [31:0] prdata_q; // captured read word
  logic [31:0] fgb_q;
  logic [31:0] fgg_q;
  logic [31:0] bgb_q;
  logic [31:0] bgg_q;
  logic [31:0] pctl_q; // load enable bit kept apart in llen_q

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------

  // source fields freeze while a transfer runs
  wire [31:0] src_mask = transfer_enable_bit ? 32'h0000_0000 : 32'hffff_ffff;
  // lut count and lut format freeze while the lut loads
  wire [31:0] lut_mask = llen_q ? 32'h0000_0000 : PCTL_LUT_LOCKED;
  wire [31:0] pctl_mask = (PCTL_XFER_LOCKED & src_mask) | lut_mask;

  // byte-lane writes on all plain registers
  pxa_wreg u_fgb (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_acc && hit_fgb),
    .strb(pstrb),
    .wdata(pwdata),
    .wmask(src_mask),
    .q(fgb_q)
  );

  pxa_wreg u_fgg (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_acc && hit_fgg),
    .strb(pstrb),
    .wdata(pwdata),
    .wmask(GAP_MASK & src_mask),
    .q(fgg_q)
  );

  pxa_wreg u_bgb (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_acc && hit_bgb),
    .strb(pstrb),
    .wdata(pwdata),
    .wmask(src_mask),
    .q(bgb_q)
  );

  pxa_wreg u_bgg (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_acc && hit_bgg),
    .strb(pstrb),
    .wdata(pwdata),
    .wmask(GAP_MASK & src_mask),
    .q(bgg_q)
  );

  // pixel control: reserved bits and load enable never stored here
  pxa_wreg u_pctl (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_pctl),
    .strb(pstrb),
    .wdata(pwdata),
    .wmask(pctl_mask),
    .q(pctl_q)
  );

  // ---------------------------------------------------------------
  // configuration check at start
  // ---------------------------------------------------------------

  wire ten_start = transfer_enable_bit && !ten_was_q;
  wire llen_start = llen_q && !llen_was_q;
  // fill mode fetches no source; only blending reads background
  wire use_fg = (pixel_conv_mode != PC_FILL);
  wire use_bg = (pixel_conv_mode == PC_BLEND);
  wire fg_bad = use_fg && layout_bad(pctl_q[PCTL_FMT_LSB +: 4], fgb_q,
                                     fgg_q[13:0]);
  wire bg_bad = use_bg && layout_bad(bg_pixel_format, bgb_q,
                                     bgg_q[13:0]);
  wire xfer_bad = ten_start && (fg_bad || bg_bad || ext_bad_config);
  wire load_bad = llen_start && ext_bad_config;
  wire bad_cfg_evt = xfer_bad || load_bad;

  // ---------------------------------------------------------------
  // lut access conflicts
  // ---------------------------------------------------------------

  wire conv_or_blend = (pixel_conv_mode == PC_CONV) || use_bg;
  wire fg_busy = llen_q || (transfer_enable_bit && conv_or_blend &&
                 indirect(pctl_q[PCTL_FMT_LSB +: 4]));
  wire bg_busy = bg_lut_load_enable || (transfer_enable_bit && use_bg &&
                 indirect(bg_pixel_format));
  // the caller drops the access while this is high
  assign lut_conflict = (fg_lut_sw_access && fg_busy) ||
                        (bg_lut_sw_access && bg_busy);

  // ---------------------------------------------------------------
  // flags and clears
  // ---------------------------------------------------------------

  wire [NFLAGS-1:0] evt;
  assign evt[BIT_BAD_CFG] = bad_cfg_evt;
  assign evt[BIT_LUT_DONE] = fg_lut_done || bg_lut_done;
  assign evt[BIT_LUT_CONF] = lut_conflict;
  assign evt[BIT_LINE_MARK] = line_mark_hit;
  assign evt[BIT_XFER_DONE] = transfer_done;
  assign evt[BIT_BUS_ERR] = bus_access_error;

  // ones in the low lane request clears; zeros do nothing
  assign clr_d = (wr_clr && pstrb[0]) ? pwdata[NFLAGS-1:0] : '0;
  // a new event in the clear cycle survives: set beats clear
  assign flag_d = (flag_q & ~clr_q) | evt;

  // ---------------------------------------------------------------
  // foreground lut load enable
  // ---------------------------------------------------------------

  // only a written one starts it; a written zero is ignored
  wire llen_set = wr_pctl && pstrb[0] && pwdata[PCTL_LLEN_BIT];
  wire llen_end = transfer_stop_bit || fg_lut_done || bad_cfg_evt ||
                  bus_access_error;
  // never alongside a transfer or background load
  wire llen_busy = transfer_enable_bit || bg_lut_load_enable;
  assign llen_d = (llen_end || llen_busy) ? 1'b0 : (llen_q || llen_set);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------

  // clear register is write-only: its read is zero
  wire [31:0] pctl_rd = pctl_q | ({31'h0, llen_q} << PCTL_LLEN_BIT);
  wire [31:0] rd_word = hit_flag ? {26'h0, flag_q} :
                        hit_fgb ? fgb_q :
                        hit_fgg ? fgg_q :
                        hit_bgb ? bgb_q :
                        hit_bgg ? bgg_q :
                        hit_pctl ? pctl_rd : 32'h0000_0000;

  // ---------------------------------------------------------------
  // sequential state
  // ---------------------------------------------------------------

  // flags and their clear strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
      clr_q <= '0;
    end else begin
      flag_q <= flag_d;
      clr_q <= clr_d;
    end
  end

  // lut load enable and start-edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      llen_q <= 1'b0;
      llen_was_q <= 1'b0;
      ten_was_q <= 1'b0;
    end else begin
      llen_q <= llen_d;
      llen_was_q <= llen_q;
      ten_was_q <= transfer_enable_bit;
    end
  end

  // abort pulse lets the control register drop the transfer enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_err_q <= 1'b0;
    end else begin
      cfg_err_q <= bad_cfg_evt;
    end
  end

  // read data taken in the setup phase, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= REG_RESET;
    end else if (setup_rd) begin
      prdata_q <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // alpha path
  // ---------------------------------------------------------------

  pxa_alpha u_alpha (
    .pclk(pclk),
    .presetn(presetn),
    .mode(pctl_q[PCTL_MODE_LSB +: 2]),
    .predef(pctl_q[PCTL_ALPHA_LSB +: 8]),
    .fetched(fg_fetched_alpha),
    .alpha_q(fg_alpha)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  assign prdata = prdata_q;
  assign flag_status = flag_q;
  // one interrupt line for six gated flags
  assign irq = |(flag_q & irq_enable);
  assign config_error = cfg_err_q;
  assign fg_base_address = fgb_q;
  assign fg_line_gap_pixels = fgg_q[13:0];
  assign bg_base_address = bgb_q;
  assign bg_line_gap_pixels = bgg_q[13:0];
  assign fg_predefined_alpha = pctl_q[PCTL_ALPHA_LSB +: 8];
  assign fg_alpha_mode = pctl_q[PCTL_MODE_LSB +: 2];
  assign fg_lut_entry_count = {1'b0, pctl_q[PCTL_CNT_LSB +: 8]} + 9'h001;
  assign fg_lut_load_enable = llen_q;
  assign fg_lut_pixel_format = pctl_q[PCTL_LPF_BIT];
  assign fg_pixel_format = pctl_q[PCTL_FMT_LSB +: 4];

endmodule : pxa_regs

// >>> tb/pxa_regs_asserts.sv
// pxa_regs_asserts: port-level checks of the flag/source register slice.
// assumes: bound into pxa_regs; one pclk domain, presetn async active low.
`timescale 1ns/1ps
module pxa_regs_asserts
  import pxa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PXA_AW-1:0] paddr,
  input wire logic transfer_enable_bit,
  input wire logic transfer_stop_bit,
  input wire logic [NFLAGS-1:0] irq_enable,
  input wire logic fg_lut_done,
  input wire logic line_mark_hit,
  input wire logic transfer_done,
  input wire logic bus_access_error,
  input wire logic [NFLAGS-1:0] flag_status,
  input wire logic irq,
  input wire logic config_error,
  input wire logic lut_conflict,
  input wire logic [31:0] fg_base_address,
  input wire logic [31:0] bg_base_address,
  input wire logic [13:0] fg_line_gap_pixels,
  input wire logic [7:0] fg_predefined_alpha,
  input wire logic [1:0] fg_alpha_mode,
  input wire logic fg_lut_load_enable,
  input wire logic [7:0] fg_alpha
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // clear write in its access cycle; a flag may only drop two edges later
  wire clr_wr = psel && penable && pwrite && (paddr == OFF_CLR);
  // sources that end a lut load, except bad configuration and the transfer/background load exclusion
  wire lut_stop = transfer_stop_bit || fg_lut_done || bus_access_error;
  // event pulses latch into their flag one cycle later; the config_error pulse rises with its flag
  a_bus_err_flag: assert property (bus_access_error |=> flag_status[BIT_BUS_ERR])
    else $error("bus error flag not set");
  a_xfer_done_flag: assert property (transfer_done |=> flag_status[BIT_XFER_DONE])
    else $error("transfer done flag not set");
  a_line_mark_flag: assert property (line_mark_hit |-> ##1 flag_status[BIT_LINE_MARK])
    else $error("line mark flag not set");
  a_lut_done_flag: assert property (fg_lut_done |=> flag_status[BIT_LUT_DONE])
    else $error("lut done flag not set");
  a_conflict_flag: assert property (lut_conflict |=> flag_status[BIT_LUT_CONF])
    else $error("lut conflict flag not set");
  a_bad_cfg_flag: assert property (config_error |-> flag_status[BIT_BAD_CFG])
    else $error("bad config pulse without flag");
  // interrupt is the or of enabled flags, no extra stage
  a_irq_merge: assert property (irq == |(flag_status & irq_enable))
    else $error("irq does not follow enabled flags");
  // flags only fall after a clear write
  a_flag_sticky: assert property (|($past(flag_status) & ~flag_status) |-> $past(clr_wr, 2))
    else $error("flag dropped without clear");
  // source fields frozen while a transfer runs
  a_src_locked: assert property ($past(transfer_enable_bit) |->
    $stable({fg_base_address, bg_base_address, fg_line_gap_pixels, fg_predefined_alpha,
      fg_alpha_mode})) else $error("source field changed during transfer");
  a_lut_abort: assert property (fg_lut_load_enable && lut_stop |=> !fg_lut_load_enable)
    else $error("lut load not ended");
  a_lut_exclusive: assert property (fg_lut_load_enable && transfer_enable_bit |=> !fg_lut_load_enable)
    else $error("lut load ran beside transfer");
  a_alpha_predef: assert property (fg_alpha_mode == AM_PREDEF |=> fg_alpha == $past(fg_predefined_alpha))
    else $error("predefined alpha not selected");
  // main scenarios reached
  c_bad_cfg: cover property (config_error);
  c_irq: cover property (irq);
  c_lut_end: cover property (fg_lut_load_enable ##1 !fg_lut_load_enable);
endmodule : pxa_regs_asserts

bind pxa_regs pxa_regs_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .transfer_enable_bit, .transfer_stop_bit, .irq_enable, .fg_lut_done, .line_mark_hit,
  .transfer_done, .bus_access_error, .flag_status, .irq, .config_error, .lut_conflict,
  .fg_base_address, .bg_base_address, .fg_line_gap_pixels, .fg_predefined_alpha,
  .fg_alpha_mode, .fg_lut_load_enable, .fg_alpha);

// >>> tb/tb.sv
// tb: directed apb tests of the flag/source register slice.
// assumes: pxa_pkg and core files compiled first; checker bound separately.
`timescale 1ns/1ps
module tb;
  import pxa_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [PXA_AW-1:0] paddr = 8'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, config_error;
  logic transfer_enable_bit = 1'b0, transfer_stop_bit = 1'b0, bg_lut_load_enable = 1'b0;
  logic [1:0] pixel_conv_mode = 2'h0;
  logic [3:0] bg_pixel_format = 4'h0;
  logic [NFLAGS-1:0] irq_enable = 6'h0;
  logic ext_bad_config = 1'b0;
  // event pulses: bus err, xfer done, line mark, fg lut access, fg lut done
  logic [4:0] ev = 5'h0;
  logic [7:0] fg_fetched_alpha = 8'h0, fg_alpha;
  logic [8:0] fg_lut_entry_count;
  int n_errors = 0, n_tests = 0, cyc = 0;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  pxa_regs dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb, .pwdata, .prdata, .pready,
    .pslverr, .transfer_enable_bit, .transfer_stop_bit, .bg_lut_load_enable, .pixel_conv_mode,
    .bg_pixel_format, .irq_enable, .ext_bad_config, .fg_lut_done(ev[4]), .bg_lut_done(1'b0),
    .line_mark_hit(ev[2]), .transfer_done(ev[1]), .bus_access_error(ev[0]),
    .fg_lut_sw_access(ev[3]), .bg_lut_sw_access(1'b0), .fg_fetched_alpha, .flag_status(),
    .irq, .config_error, .lut_conflict(), .fg_base_address(), .fg_line_gap_pixels(),
    .bg_base_address(), .bg_line_gap_pixels(), .fg_predefined_alpha(), .fg_alpha_mode(),
    .fg_lut_entry_count, .fg_lut_load_enable(), .fg_lut_pixel_format(), .fg_pixel_format(),
    .fg_alpha
  );

  // verdict in one place
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer: hold until pready high, then idle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, x);
  endtask : rd

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
    @(posedge pclk);
  endtask : pulse

  // program sources, start a transfer, expect the bad-config pulse or not
  task automatic cfg(input logic [3:0] ff, input logic [31:0] fb, input logic [13:0] fgp,
                     input logic [1:0] m, input logic bad, input logic [3:0] bf = FMT_ARGB8888,
                     input logic [31:0] bb = 32'h0, input logic [13:0] bgp = 14'h0);
    wr(OFF_FG_PCTL, {28'h0, ff}, 4'hf);
    wr(OFF_FG_BASE, fb, 4'hf);
    wr(OFF_FG_GAP, {18'h0, fgp}, 4'hf);
    wr(OFF_BG_BASE, bb, 4'hf);
    wr(OFF_BG_GAP, {18'h0, bgp}, 4'hf);
    bg_pixel_format <= bf;
    pixel_conv_mode <= m;
    @(posedge pclk);
    transfer_enable_bit <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, config_error}, {31'h0, bad});
    @(posedge pclk);
    transfer_enable_bit <= 1'b0;
    rd(OFF_FLAG, {26'h0, bad, 5'h0});
    wr(OFF_CLR, 32'h20, 4'h1);
  endtask : cfg

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial begin
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, reserved bits, lanes, unmapped offsets
    for (int a = 4; a < 32; a += 4) rd(8'(a), REG_RESET);
    apb(1'b0, 8'h20, 32'h0, 4'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(OFF_FG_GAP, 32'hffff_ffff, 4'hf);
    rd(OFF_FG_GAP, 32'h3fff);
    wr(OFF_BG_GAP, 32'hffff_ffff, 4'hc);
    rd(OFF_BG_GAP, 32'h0);
    wr(OFF_BG_BASE, 32'haabb_ccdd, 4'h2);
    rd(OFF_BG_BASE, 32'h0000_cc00);
    wr(OFF_FLAG, 32'h3f, 4'hf);
    rd(OFF_FLAG, 32'h0);
    done("regs");
    // each event sets its flag, raises irq, masked irq, clear by lane 0
    irq_enable <= 6'h3f;
    for (int i = 0; i < 5; i++) begin
      if (i == 3) wr(OFF_FG_PCTL, 32'h20, 4'h1);
      pulse(i);
      chk({31'h0, irq}, 32'h1);
      irq_enable <= ~(6'h1 << i);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      irq_enable <= 6'h3f;
      rd(OFF_FLAG, 32'h1 << i);
      wr(OFF_CLR, 32'h0, 4'h1);
      rd(OFF_FLAG, 32'h1 << i);
      wr(OFF_CLR, 32'h1 << i, 4'h1);
      rd(OFF_FLAG, 32'h0);
    end
    done("flags");
    // configuration checks at transfer start
    cfg(FMT_ARGB8888, 32'h2, 14'h0, PC_COPY, 1'b1);
    cfg(FMT_RGB565, 32'h1, 14'h0, PC_CONV, 1'b1);
    cfg(FMT_AL88, 32'h2, 14'h0, PC_COPY, 1'b0);
    cfg(FMT_L4, 32'h0, 14'h3, PC_CONV, 1'b1);
    cfg(FMT_A4, 32'h0, 14'h2, PC_COPY, 1'b0);
    cfg(FMT_ARGB8888, 32'h0, 14'h0, PC_BLEND, 1'b1, FMT_ARGB1555, 32'h1);
    cfg(FMT_ARGB8888, 32'h0, 14'h0, PC_BLEND, 1'b1, FMT_A4, 32'h0, 14'h1);
    cfg(FMT_ARGB8888, 32'h2, 14'h0, PC_FILL, 1'b0);
    cfg(4'hb, 32'h0, 14'h0, PC_COPY, 1'b1);
    ext_bad_config <= 1'b1;
    cfg(FMT_ARGB8888, 32'h40, 14'h0, PC_COPY, 1'b1);
    ext_bad_config <= 1'b0;
    cfg(FMT_ARGB8888, 32'h40, 14'h0, PC_COPY, 1'b0);
    done("config");
    // running lut load dropped by transfer; source fields locked
    wr(OFF_FG_PCTL, 32'h20, 4'h1);
    transfer_enable_bit <= 1'b1;
    @(posedge pclk);
    wr(OFF_FG_BASE, 32'h1234_5678, 4'hf);
    wr(OFF_FG_PCTL, 32'hff01_0000, 4'hc);
    rd(OFF_FG_BASE, 32'h40);
    rd(OFF_FG_PCTL, 32'h0);
    transfer_enable_bit <= 1'b0;
    done("lock");
    // lut count plus one, locked while loading, stop ends the load
    wr(OFF_FG_PCTL, 32'h0520, 4'h3);
    rd(OFF_FG_PCTL, 32'h0520);
    chk({23'h0, fg_lut_entry_count}, 32'h6);
    wr(OFF_FG_PCTL, 32'h0900, 4'h2);
    rd(OFF_FG_PCTL, 32'h0520);
    transfer_stop_bit <= 1'b1;
    @(posedge pclk);
    transfer_stop_bit <= 1'b0;
    @(posedge pclk);
    rd(OFF_FG_PCTL, 32'h0500);
    bg_lut_load_enable <= 1'b1;
    wr(OFF_FG_PCTL, 32'h20, 4'h1);
    rd(OFF_FG_PCTL, 32'h0500);
    done("lut");
    // alpha modes: keep, predefined, scaled by /255 rounded
    fg_fetched_alpha <= 8'h40;
    for (int m = 0; m < 3; m++) begin
      wr(OFF_FG_PCTL, {8'h80, 6'h0, 2'(m), 16'h0}, 4'hf);
      @(negedge pclk);
      chk({24'h0, fg_alpha}, m == 0 ? 32'h40 : m == 1 ? 32'h80 : 32'h20);
      @(posedge pclk);
    end
    done("alpha");
    summarize();
  end
endmodule : tb
